// ### core/ecp_counter_pair.sv
// One perf_monitor counter/control pair with event shaping
`timescale 1ns/1ns
`include "ecp_defines.svh"

// Notes on behaviour
// - Event selector bits 7:0 choose the event fed to the counter.
// - Subevent filter bits 15:8 choose which subevents are counted.
// - Threshold bits 31:24; increment compared against it before counting.
// - Edge mode bit 18 counts rising transitions, else every active cycle.
// - Edge detection follows threshold; software sets nonzero threshold.
// - Writing 1 to bit 17 clears the counter; bit reads zero.
// - Counter is 64 bits; 43:0 hold the tally, 63:44 ignored.
// - Counter readable any time without disturbing accumulation.
// - One cycle may add up to an eight-bit amount.
// - Box freeze stops the counter from advancing.
// - Overflow sets this counter's wrap flag; write of one clears it.
module ecp_counter_pair (
  input  wire logic                    mclk_i,
  input  wire logic                    reset_n_i,
  input  wire ecp_pkg::ecp_req_t       req_i,
  input  wire logic [7:0]              event_inc_i,
  input  wire logic                    freeze_i,
  input  wire logic                    flag_clr_i,
  output logic [`ECP_CTL_W-1:0]        ctl_rdata_o,
  output logic [`ECP_CTR_W-1:0]        ctr_rdata_o,
  output ecp_pkg::ecp_sel_t            sel_o,
  output logic                         overflow_o,
  output logic                         wrap_flag_o
);

  //////////////////////////////////////////////////////////////////////////
  // Control register
  ecp_pkg::ecp_ctl_t           ctl_q, ctl_d;
  logic [`ECP_TALLY_W-1:0]     tally_q, tally_d;
  logic                        shaped_q, shaped_d;
  logic                        ovf_q, ovf_d;
  logic                        flag_q, flag_d;
  logic                        ctl_wr, ctr_wr, clear_req;
  logic                        over_thr, count_en;
  logic [`ECP_TALLY_W:0]       sum;
  logic [`ECP_TALLY_W-1:0]     add_amt;

  function automatic logic [`ECP_CTL_W-1:0] ctl_view(
    input ecp_pkg::ecp_ctl_t c);
    logic [`ECP_CTL_W-1:0] v;
    v = c;
    v[`ECP_CLEAR_BIT] = 1'b0;
    return v;
  endfunction

  function automatic logic thr_off(input ecp_pkg::ecp_ctl_t c);
    return c.thresh == `ECP_THRESH_OFF;
  endfunction

  assign ctl_wr    = req_i.wr && !req_i.sel_ctr;
  assign ctr_wr    = req_i.wr && req_i.sel_ctr;
  assign clear_req = ctl_wr && req_i.wdata[`ECP_CLEAR_BIT];

  always_comb begin
    ctl_d = ctl_q;
    if (ctl_wr) begin
      ctl_d = ecp_pkg::ecp_ctl_t'(req_i.wdata[`ECP_CTL_W-1:0]);
      ctl_d.clear = 1'b0;
      ctl_d.unused_bits = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_q <= ecp_pkg::ecp_ctl_t'(`ECP_CTL_RST);
    end else begin
      ctl_q <= ctl_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event shaping: threshold then edge detection
  assign over_thr = event_inc_i >= ctl_q.thresh;
  assign count_en = ctl_q.gate && !freeze_i;

  always_comb begin
    shaped_d = over_thr;
    add_amt  = '0;
    if (thr_off(ctl_q)) begin
      add_amt = `ECP_TALLY_W'(event_inc_i);
    end else if (ctl_q.edge_mode) begin
      add_amt = (over_thr && !shaped_q) ? `ECP_TALLY_ONE
                                        : `ECP_TALLY_RST;
    end else if (over_thr) begin
      add_amt = `ECP_TALLY_W'(event_inc_i);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Tally and overflow
  assign sum = {1'b0, tally_q} + {1'b0, add_amt};

  always_comb begin
    tally_d = tally_q;
    ovf_d   = 1'b0;
    flag_d  = flag_q && !flag_clr_i;
    if (clear_req) begin
      tally_d = `ECP_TALLY_RST;
    end else if (ctr_wr) begin
      tally_d = req_i.wdata[`ECP_TALLY_W-1:0];
    end else if (count_en) begin
      tally_d = sum[`ECP_TALLY_W-1:0];
      ovf_d   = sum[`ECP_TALLY_W];
    end
    if (ovf_d) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tally_q  <= `ECP_TALLY_RST;
      shaped_q <= 1'b0;
      ovf_q    <= 1'b0;
      flag_q   <= 1'b0;
    end else begin
      tally_q  <= tally_d;
      shaped_q <= shaped_d;
      ovf_q    <= ovf_d;
      flag_q   <= flag_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data and outputs
  logic [`ECP_CTL_W-1:0] ctl_rd_q, ctl_rd_d;
  logic [`ECP_CTR_W-1:0] ctr_rd_q, ctr_rd_d;
  ecp_pkg::ecp_sel_t     sel_q, sel_d;

  always_comb begin
    ctl_rd_d = ctl_view(ctl_d);
    ctr_rd_d = `ECP_CTR_W'(tally_d);
    sel_d    = '{sel: ctl_d.event_selector,
                 sub: ctl_d.subevent};
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_rd_q <= `ECP_CTL_RST;
      ctr_rd_q <= '0;
      sel_q    <= '0;
    end else begin
      ctl_rd_q <= ctl_rd_d;
      ctr_rd_q <= ctr_rd_d;
      sel_q    <= sel_d;
    end
  end

  assign ctl_rdata_o = ctl_rd_q;
  assign ctr_rdata_o = ctr_rd_q;
  assign sel_o       = sel_q;
  assign overflow_o  = ovf_q;
  assign wrap_flag_o = flag_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  clear_zeroes_a: assert property (clear_req |=> tally_q == '0)
    else $error("clear did not zero counter");
  gate_holds_a: assert property (
    !ctl_q.gate && !req_i.wr |=> $stable(tally_q))
    else $error("counter moved with gate off");
  freeze_holds_a: assert property (
    freeze_i && !req_i.wr |=> $stable(tally_q))
    else $error("counter moved while frozen");
  edge_single_a: assert property (
    count_en && ctl_q.edge_mode && !thr_off(ctl_q) && !req_i.wr
    |=> (tally_q - $past(tally_q)) <= `ECP_TALLY_ONE)
    else $error("edge mode added more than one");
  level_adds_a: assert property (
    count_en && !ctl_q.edge_mode && over_thr && !req_i.wr
    && !sum[`ECP_TALLY_W]
    |=> tally_q == $past(tally_q) + $past(event_inc_i))
    else $error("level mode wrong increment");
  below_thr_a: assert property (
    !thr_off(ctl_q) && !over_thr && !req_i.wr |=> $stable(tally_q))
    else $error("counted below threshold");
  wrap_flag_a: assert property (ovf_q |-> flag_q)
    else $error("wrap did not set flag");
  clear_bit_a: assert property (ctl_rdata_o[`ECP_CLEAR_BIT] == 1'b0)
    else $error("clear bit read back");
  sel_track_a: assert property (
    ctl_wr
    |=> sel_o.sel == $past(req_i.wdata[`ECP_EVSEL_MSB:`ECP_EVSEL_LSB]))
    else $error("selector not presented");
  flag_clear_a: assert property (flag_clr_i && !ovf_d |=> !flag_q)
    else $error("flag not cleared");

  sub_track_a: assert property (
    ctl_wr
    |=> sel_o.sub == $past(req_i.wdata[`ECP_SUBEV_MSB:`ECP_SUBEV_LSB]))
    else $error("subevent filter not presented");
  ign_bit_a: assert property (ctl_rdata_o[`ECP_IGN_BIT] == 1'b0)
    else $error("ignored bit read back");
  ctr_load_a: assert property (
    ctr_wr |=> tally_q == $past(req_i.wdata[`ECP_TALLY_W-1:0]))
    else $error("counter write not loaded");
  raw_adds_a: assert property (
    count_en && thr_off(ctl_q) && !req_i.wr && !sum[`ECP_TALLY_W]
    |=> tally_q == $past(tally_q) + $past(event_inc_i))
    else $error("raw increment not added");
  edge_rise_a: assert property (
    count_en && ctl_q.edge_mode && !thr_off(ctl_q) && !req_i.wr
    && over_thr && !shaped_q
    |=> tally_q == $past(tally_q) + `ECP_TALLY_ONE)
    else $error("rising edge not counted");
  wrap_pulse_a: assert property (
    count_en && !clear_req && !ctr_wr && sum[`ECP_TALLY_W]
    |=> overflow_o && tally_q == $past(sum[`ECP_TALLY_W-1:0]))
    else $error("wrap did not pulse overflow");
  flag_sticky_a: assert property (
    wrap_flag_o && !flag_clr_i |=> wrap_flag_o)
    else $error("wrap flag lost");

  edge_cnt_c: cover property (count_en && ctl_q.edge_mode && add_amt != '0);
  wrap_c:     cover property (ovf_q);
  clear_c:    cover property (clear_req && count_en);
  freeze_c:   cover property (freeze_i && ctl_q.gate);
  level_c:    cover property (count_en && !ctl_q.edge_mode && over_thr);
endmodule

// ### common/ecp_defines.svh
// Field positions, widths and reset values of the counter/control pair
`ifndef ECP_DEFINES_SVH
`define ECP_DEFINES_SVH
`define ECP_CTL_W        32
`define ECP_CTR_W        64
`define ECP_TALLY_W      44
`define ECP_INC_W        8
`define ECP_EVSEL_LSB    0
`define ECP_EVSEL_MSB    7
`define ECP_SUBEV_LSB    8
`define ECP_SUBEV_MSB    15
`define ECP_CLEAR_BIT    17
`define ECP_EDGE_BIT     18
`define ECP_IGN_BIT      19
`define ECP_THRESH_OFF   8'h00
`define ECP_GATE_BIT     22
`define ECP_THRESH_LSB   24
`define ECP_THRESH_MSB   31
`define ECP_CTL_RST      32'h00000000
`define ECP_TALLY_RST    44'h00000000000
`define ECP_TALLY_ONE    44'h00000000001
`define ECP_FLAG_IDX_W   2
`endif

// ### common/ecp_pkg.sv
// Types of the counter/control pair
package ecp_pkg;
  typedef struct packed {
    logic [7:0] thresh;
    logic       rsv23;
    logic       gate;
    logic [1:0] rsv21;
    logic       unused_bits;
    logic       edge_mode;
    logic       clear;
    logic       rsv16;
    logic [7:0] subevent;
    logic [7:0] event_selector;
  } ecp_ctl_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        sel_ctr;
    logic [63:0] wdata;
  } ecp_req_t;

  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] sub;
  } ecp_sel_t;
endpackage

// ### test/ecp_event_src.sv
// Event source model driving the per-cycle increment
`timescale 1ns/1ns
module ecp_event_src (
  input  wire logic       mclk_i,
  input  wire logic [7:0] mask_i,
  output logic      [7:0] inc_o
);
  logic [31:0] lfsr_q = 32'hA88699A2;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial inc_o = 8'h00;
  // New value after each falling edge, zero outside masked bits
  always @(negedge mclk_i) begin
    lfsr_q <= lfsr(lfsr_q);
    inc_o  <= lfsr_q[7:0] & mask_i;
  end
endmodule

// ### test/tb_ecp_counter_pair.sv
// Self-checking bench for the counter/control pair
`timescale 1ns/1ns
module tb_ecp_counter_pair;
  logic              mclk_i = 0, reset_n_i = 0, freeze_i = 0, flag_clr_i = 0;
  logic              look = 0, ov, flag, prev = 0;
  ecp_pkg::ecp_req_t req = '0;
  ecp_pkg::ecp_sel_t sel;
  logic [7:0]        inc, thr, mask = 8'h00;
  logic [31:0]       ctl_o, cfg = 32'h0;
  logic [63:0]       ctr_o;
  logic [43:0]       tally = 44'h0;
  logic [65:0]       q[$], e;
  int                err_count = 0, n_tests = 0, ov_n = 0;
  ecp_counter_pair dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req),
    .event_inc_i(inc), .freeze_i(freeze_i), .flag_clr_i(flag_clr_i),
    .ctl_rdata_o(ctl_o), .ctr_rdata_o(ctr_o), .sel_o(sel),
    .overflow_o(ov), .wrap_flag_o(flag));
  ecp_event_src src (.mclk_i(mclk_i), .mask_i(mask), .inc_o(inc));
  initial forever #10 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic note(input logic [1:0] k, input logic [63:0] x);
    q.push_back({k, x});
    @(negedge mclk_i) look = 1;
    @(negedge mclk_i) look = 0;
  endtask
  // Counter read while events still arrive
  task automatic peek;
    q.push_back({2'h0, 20'h0, tally});
    look = 1;
    @(negedge mclk_i) look = 0;
  endtask
  task automatic wr(input logic s, input logic [63:0] d);
    @(negedge mclk_i) req = '{wr: 1'b1, rd: 1'b0, sel_ctr: s, wdata: d};
    @(negedge mclk_i) req.wr = 1'b0;
    if (s) tally = d[43:0];
    else begin
      cfg = d[31:0];
      if (d[17]) tally = 44'h0;
    end
  endtask
  task automatic run(input logic [31:0] c, input logic [7:0] m, input int n);
    wr(1'b0, {32'h0, c});
    mask <= m;
    repeat (n) @(negedge mclk_i);
    peek;
    mask <= 8'h00;
    repeat (3) @(negedge mclk_i);
    note(2'h0, {20'h0, tally});
    $display("test ctl=%h done", c);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reference tally and result monitor
  always @(posedge mclk_i) begin
    thr = cfg[31:24];
    if (cfg[22] && !freeze_i)
      tally <= tally + (thr == 0 ? inc : cfg[18] ? (inc >= thr && !prev)
                                       : (inc >= thr ? inc : 8'h00));
    prev <= inc >= thr;
    if (ov) ov_n++;
    if (look && q.size() > 0) begin
      e = q.pop_front();
      case (e[65:64])
        2'h0:    chk(ctr_o, e[63:0]);
        2'h1:    chk({32'h0, ctl_o}, e[63:0]);
        2'h2:    chk({48'h0, sel}, e[63:0]);
        default: chk({32'(ov_n), 31'h0, flag}, e[63:0]);
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge mclk_i);
    reset_n_i = 1;
    note(2'h1, 64'h0);
    note(2'h0, 64'h0);
    $display("test power-on reset done");
    wr(1'b0, 64'h004EAA42);
    note(2'h1, 64'h0044AA42);
    note(2'h2, 64'h42AA);
    $display("test control fields done");
    run(32'h00400000, 8'hFF, 8);
    run(32'h05400000, 8'h0F, 12);
    run(32'h01440000, 8'h01, 12);
    run(32'h01000000, 8'hFF, 6);
    freeze_i = 1;
    run(32'h00400000, 8'hFF, 6);
    freeze_i = 0;
    run(32'h00420000, 8'h00, 1);
    wr(1'b1, 64'hFFFF_FFFF_FFFF_FFFF);
    note(2'h0, 64'h00000FFFFFFFFFFF);
    run(32'h00400000, 8'hFF, 8);
    note(2'h3, 64'h0000000100000001);
    @(negedge mclk_i) flag_clr_i = 1;
    @(negedge mclk_i) flag_clr_i = 0;
    note(2'h3, 64'h0000000100000000);
    $display("test wrap flag done");
    reset_n_i = 0;
    cfg = 32'h0;
    tally = 44'h0;
    @(negedge mclk_i) reset_n_i = 1;
    note(2'h1, 64'h0);
    note(2'h0, 64'h0);
    $display("test mid-run reset done");
    complete_run;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #20000;
    err_count++;
    complete_run;
  end
endmodule
